/* File: adcsq_assertions.sv */
// Checker: bus and converter timing relations at the top ports
`timescale 1ns/1ns
module adcsq_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire adcsq_pkg::adcsq_wb_req_t wb_req_i,
   input wire adcsq_pkg::adcsq_wb_rsp_t wb_rsp_o,
   input wire logic event_start_i,
   input wire logic [11:0] conv_code_i,
   input wire adcsq_pkg::adcsq_ana_t ana_o,
   input wire logic done_event_o,
   input wire logic cmp_event_o
);
   import adcsq_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   sequence s_req;
      wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack && ce_i;
   endsequence
   sequence s_start;
      $rose(ana_o.busy);
   endsequence
   property p_ack_answer;
      s_req |=> wb_rsp_o.ack;
   endproperty
   property p_ack_pulse;
      wb_rsp_o.ack && ce_i |=> !wb_rsp_o.ack;
   endproperty
   property p_neg_gain;
      ana_o.gain_en |-> ana_o.neg_mode == ADCSQ_NEG_PIN && ana_o.neg_pin[2];
   endproperty
   property p_cmp_done;
      cmp_event_o |-> done_event_o;
   endproperty
   property p_done_pulse;
      done_event_o && ce_i |-> $past(ana_o.busy) ##1 !done_event_o;
   endproperty
   property p_sample_first;
      s_start |-> ana_o.sample;
   endproperty
   property p_sample_busy;
      ana_o.sample |-> ana_o.busy;
   endproperty
   property p_sel_hold;
      !$rose(ana_o.sample) |-> $stable(ana_o.pos_sel) && $stable(ana_o.gain);
   endproperty
   ////////////////////////////////////////////////////////////////////////
   a_ack_answer: assert property (p_ack_answer)
      else $error("bus request not acknowledged next cycle");
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   a_neg_gain: assert property (p_neg_gain)
      else $error("gain stage negative input outside pins four to seven");
   a_cmp_done: assert property (p_cmp_done)
      else $error("compare event without done event");
   a_done_pulse: assert property (p_done_pulse)
      else $error("done event not a single pulse within a run");
   a_sample_first: assert property (p_sample_first)
      else $error("input not sampled at conversion start");
   a_sample_busy: assert property (p_sample_busy)
      else $error("sampling outside a conversion");
   a_sel_hold: assert property (p_sel_hold)
      else $error("input selection changed mid conversion");
endmodule : adcsq_assertions

/* File: adcsq_conv_model.sv */
// Partner: analog inputs giving a code per selected positive input
`timescale 1ns/1ns
module adcsq_conv_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire adcsq_pkg::adcsq_ana_t ana_i,
   input wire logic [11:0] value_i,
   output logic [11:0] code_o
);
   import adcsq_pkg::*;
   logic [11:0] held;
   logic samp_q;
   always_ff @(posedge clk_i) begin
      samp_q <= ana_i.sample;
      if (rst_i) begin
         held <= 12'h000;
      end else if (ana_i.sample && !samp_q) begin
         held <= value_i + {8'h00, ana_i.pos_sel};
      end
   end
   // Outside a conversion the code is not held
   assign code_o = ana_i.busy ? held : ~held;
endmodule : adcsq_conv_model

/* File: adcsq_pkg.sv */
// Package: constants and carriers for the converter sequencer
package adcsq_pkg;

   // Register byte offsets
   localparam logic [7:0] ADCSQ_OFF_CTRL = 8'h00;
   localparam logic [7:0] ADCSQ_OFF_CFG = 8'h04;
   localparam logic [7:0] ADCSQ_OFF_INSEL = 8'h08;
   localparam logic [7:0] ADCSQ_OFF_SAMP = 8'h0C;
   localparam logic [7:0] ADCSQ_OFF_CMP = 8'h10;
   localparam logic [7:0] ADCSQ_OFF_RESULT = 8'h14;
   localparam logic [7:0] ADCSQ_OFF_STATUS = 8'h18;

   // Field positions
   localparam int ADCSQ_CTRL_ENABLE = 0;
   localparam int ADCSQ_CTRL_START = 2;
   localparam int ADCSQ_CTRL_FREERUN = 3;
   localparam int ADCSQ_CFG_RES_LO = 1;
   localparam int ADCSQ_CFG_SIGNED = 4;
   localparam int ADCSQ_CFG_PRESC_LO = 8;
   localparam int ADCSQ_INSEL_TYPE_LO = 0;
   localparam int ADCSQ_INSEL_GAIN_LO = 2;
   localparam int ADCSQ_INSEL_POS_LO = 8;
   localparam int ADCSQ_INSEL_NEG_LO = 12;
   localparam int ADCSQ_INSEL_SCAN_LO = 16;
   localparam int ADCSQ_CMP_ABOVE = 16;
   localparam int ADCSQ_ST_DONE = 0;
   localparam int ADCSQ_ST_CMP = 1;
   localparam int ADCSQ_ST_BUSY = 2;
   localparam int ADCSQ_ST_CFGERR = 3;

   // Reset values
   localparam logic [31:0] ADCSQ_RST_REG = 32'h0000_0000;

   // Resolution codes
   localparam logic [1:0] ADCSQ_RES_12R = 2'h0;
   localparam logic [1:0] ADCSQ_RES_RSVD = 2'h1;
   localparam logic [1:0] ADCSQ_RES_8R = 2'h2;
   localparam logic [1:0] ADCSQ_RES_12L = 2'h3;

   // Timeline in converter half-cycles: 2*(1+(RES+1)/2)
   localparam logic [7:0] ADCSQ_HALF_12 = 8'h0F;
   localparam logic [7:0] ADCSQ_HALF_8 = 8'h0B;
   localparam logic [7:0] ADCSQ_HALF_SAMPLE = 8'h01;
   localparam logic [6:0] ADCSQ_HALF_EXT_MAX = 7'h7F;

   // Gain codes: 0=1x .. 6=64x, 7=1/2x
   localparam logic [2:0] ADCSQ_GAIN_HALF = 3'h7;

   typedef enum logic [1:0] {
      ADCSQ_IN_INTERNAL = 2'b00,
      ADCSQ_IN_SINGLE = 2'b01,
      ADCSQ_IN_DIFF = 2'b10,
      ADCSQ_IN_DIFF_GAIN = 2'b11
   } adcsq_in_type_t;

   typedef enum logic [1:0] {
      ADCSQ_NEG_PIN = 2'b00,
      ADCSQ_NEG_INT_GND = 2'b01,
      ADCSQ_NEG_HALF_VREF = 2'b10
   } adcsq_neg_mode_t;

   typedef enum logic [1:0] {
      ADCSQ_S_IDLE = 2'b00,
      ADCSQ_S_RUN = 2'b01
   } adcsq_state_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } adcsq_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } adcsq_wb_rsp_t;

   typedef struct packed {
      logic converter_clock;
      logic sample;
      logic busy;
      logic pos_internal;
      logic [3:0] pos_sel;
      adcsq_neg_mode_t neg_mode;
      logic [2:0] neg_pin;
      logic gain_en;
      logic [2:0] gain;
   } adcsq_ana_t;

endpackage : adcsq_pkg

/* File: adcsq_tb.sv */
// Testbench: formatting, routing, timing, compare and scan
`timescale 1ns/1ns
module testbench;
   import adcsq_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ev = 1'b0;
   logic ce = 1'b1;
   logic [11:0] mval = 12'h000;
   logic [11:0] code;
   adcsq_wb_req_t req = '0;
   adcsq_wb_rsp_t rsp;
   adcsq_ana_t ana;
   logic done;
   logic cmp;
   integer seed = 32'h3E5E;
   int num_errors = 0;
   int checks_done = 0;
   logic [31:0] rd;
   logic [31:0] rnd;
   logic [11:0] cv;
   int n;
   adcsq_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_req_i(req),
      .wb_rsp_o(rsp), .event_start_i(ev), .conv_code_i(code), .ana_o(ana),
      .done_event_o(done), .cmp_event_o(cmp));
   adcsq_conv_model mdl (.clk_i(clk_i), .rst_i(rst_i), .ana_i(ana), .value_i(mval),
      .code_o(code));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      n = 0;
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.ack !== 1'b1);
      rd = rsp.dat;
      req <= '0;
   endtask : wb
   function automatic logic [15:0] fmt(logic [11:0] c, logic [1:0] r, logic s);
      case (r)
         2'h2: fmt = {{8{s & c[11]}}, c[11:4]};
         2'h3: fmt = {c, 4'h0};
         default: fmt = {{4{s & c[11]}}, c};
      endcase
   endfunction : fmt
   task automatic conv(input logic [1:0] r, ty, ns, input logic s, ab, e,
      input logic [2:0] g, input logic [3:0] p, input logic [6:0] x,
      input logic [11:0] v, t, input logic [1:0] pr);
      int lat;
      logic hi;
      logic lo;
      mval <= v;
      cv = v + {8'h00, p};
      wb(1'b1, ADCSQ_OFF_CFG, 32'(s) << ADCSQ_CFG_SIGNED | 32'(r) << ADCSQ_CFG_RES_LO
         | 32'(pr) << ADCSQ_CFG_PRESC_LO);
      wb(1'b1, ADCSQ_OFF_INSEL, 32'(ty) | 32'(g) << ADCSQ_INSEL_GAIN_LO
         | 32'(p) << ADCSQ_INSEL_POS_LO | 32'(ns) << ADCSQ_INSEL_NEG_LO);
      wb(1'b1, ADCSQ_OFF_SAMP, 32'(x));
      wb(1'b1, ADCSQ_OFF_CMP, 32'(t) | 32'(ab) << ADCSQ_CMP_ABOVE);
      if (e) begin
         wb(1'b1, ADCSQ_OFF_CTRL, 32'h1);
         ev <= 1'b1;
         @(posedge clk_i);
         ev <= 1'b0;
      end else begin
         wb(1'b1, ADCSQ_OFF_CTRL, 32'h5);
      end
      n = 0;
      while (ana.busy !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(ana.pos_internal), 32'(ty == 2'h0));
      chk(32'(ana.pos_sel), 32'(p));
      chk(32'(ana.neg_mode), ty[1] ? 32'h0 : (s ? 32'h1 : 32'h2));
      if (ty == 2'h3) chk(32'({ana.gain_en, ana.gain, ana.neg_pin}), 32'({1'b1, g, 1'b1, ns}));
      lat = (r == 2'h2 ? 11 : 15) + int'(x) + (ty != 2'h3 ? 0 : (g == 3'h7 ? 1 : int'(g)));
      lat = lat << pr;
      n = 0;
      while (done !== 1'b1 && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
      hi = s ? ($signed(cv) > $signed(t)) : (cv > t);
      lo = s ? ($signed(cv) < $signed(t)) : (cv < t);
      if (r != 2'h2) chk(32'(cmp), 32'(ab ? hi : lo));
      chk(32'(n), 32'(lat));
      wb(1'b0, ADCSQ_OFF_RESULT, 32'h0);
      chk(rd, 32'(fmt(cv, r, s)));
      wb(1'b0, ADCSQ_OFF_CTRL, 32'h0);
      chk(rd, 32'h1);
      wb(1'b0, ADCSQ_OFF_STATUS, 32'h0);
      chk(32'(rd[ADCSQ_ST_DONE]), 32'h1);
      wb(1'b1, ADCSQ_OFF_STATUS, 32'h3);
   endtask : conv
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (30000) @(posedge clk_i);
      num_errors++;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, ADCSQ_OFF_CFG, 32'h0);
      chk(rd, ADCSQ_RST_REG);
      wb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < 16; i++) begin
         rnd = $random(seed);
         cv = (i < 4) ? (12'h7FF + 12'(i)) : rnd[27:16];
         // Differential types always signed
         conv(2'(i), rnd[1:0], rnd[3:2], rnd[1] | rnd[4] | (i < 2), rnd[5], i[2],
            rnd[8:6], i < 4 ? 4'h0 : rnd[12:9], i == 3 ? 7'h7F : {4'h0, rnd[15:13]},
            cv, 12'($random(seed)), rnd[31:30]);
      end
      wb(1'b1, ADCSQ_OFF_CFG, 32'h0);
      wb(1'b1, ADCSQ_OFF_INSEL, 32'h0002_0501);
      wb(1'b1, ADCSQ_OFF_SAMP, 32'h0);
      mval <= 12'h100;
      // Freerun restarts the scan at its base
      wb(1'b1, ADCSQ_OFF_CTRL, 32'hD);
      for (int k = 0; k < 4; k++) begin
         n = 0;
         do begin
            @(posedge clk_i);
            n++;
         end while (done !== 1'b1 && n < 400);
         chk(32'(ana.pos_sel), 32'(5 + (k + 1) % 3));
         if (k > 0) chk(32'(n), 32'd15);
      end
      wb(1'b1, ADCSQ_OFF_CTRL, 32'h1);
      repeat (40) @(posedge clk_i);
      chk(32'(ana.busy), 32'h0);
      // Frozen clock enable stalls the bus answer by five cycles
      ce <= 1'b0;
      fork
         begin
            repeat (6) @(posedge clk_i);
            ce <= 1'b1;
         end
         wb(1'b0, ADCSQ_OFF_RESULT, 32'h0);
      join
      chk(32'(n), 32'd7);
      chk(rd, 32'h107);
      finish_test();
   end
endmodule : testbench
bind adcsq_top adcsq_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .event_start_i(event_start_i),
   .conv_code_i(conv_code_i), .ana_o(ana_o), .done_event_o(done_event_o),
   .cmp_event_o(cmp_event_o));

/* File: adcsq_top.sv */
// Top: converter sequencer, result formatting, compare and bus slave
//
// Notes on behaviour
// - With gain, any positive pin; negative pin only from pins four to seven.
// - Gain offers eight settings from one half to sixty-four times.
// - Single-ended signed measurements use internal ground as negative input.
// - Unsigned single-ended or internal use half reference minus five percent.
// - Sampling extends by half converter cycles, up to sixty-four cycles.
// - Signed or unsigned is one global setting for core and channel.
// - Signed 12-bit results span 0xF800 to 0x07FF.
// - Unsigned 12-bit results span 0x0000 to 0x0FFF.
// - Result is 16 bits; 8-bit right aligned, 12-bit right or left.
// - Signed 12-bit right aligned pads bit 11 into bits 12 to 15.
// - Signed 8-bit pads bit 7 across the upper byte.
// - Compare against 12-bit threshold; event only above or below as set.
// - Start by software start bit or by incoming event; both are accepted, with no source select.
// - Scan starts at lowest positive input and steps up per conversion.
// - Converter clock comes from peripheral clock through a prescaler.
// - Latency is one plus (resolution+1)/2 plus gain cycles.
// - Msb first, rest over three or five cycles; last cycle prepares result.
// - A new conversion may begin right after the previous one completes.
// - Input is sampled during first half of the first converter cycle.
// - Resolution 00 12-bit right, 10 8-bit right, 11 12-bit left, 01 reserved.
// - Signed select is clear after reset, meaning unsigned.
// - Start bit clears itself once the conversion has started.
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module adcsq_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire adcsq_pkg::adcsq_wb_req_t wb_req_i,
   output adcsq_pkg::adcsq_wb_rsp_t wb_rsp_o,
   input wire logic event_start_i,
   input wire logic [11:0] conv_code_i,
   output adcsq_pkg::adcsq_ana_t ana_o,
   output logic done_event_o,
   output logic cmp_event_o
);
   import adcsq_pkg::*;

   typedef struct packed {
      adcsq_wb_rsp_t rsp;
      adcsq_ana_t ana;
      logic done_ev;
      logic cmp_ev;
      logic [31:0] ctrl;
      logic [31:0] cfg;
      logic [31:0] insel;
      logic [31:0] samp;
      logic [31:0] cmp;
      logic [15:0] result;
      logic st_done;
      logic st_cmp;
      logic ev_pend;
      adcsq_state_t state;
      logic [6:0] presc;
      logic [7:0] half;
      logic [7:0] half_last;
      logic [3:0] scan_off;
      logic [11:0] sync1;
      logic [11:0] sync2;
      logic [11:0] sync3;
      logic [11:0] code;
   } adcsq_reg_t;

   adcsq_reg_t r;
   adcsq_reg_t next_r;
   logic [11:0] next_code;

   ////////////////////////////////////////////////////////////////////////
   // Analog code input: three-stage capture, accept when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < 12; gi++) begin : g_code
         assign next_code[gi] = (r.sync2[gi] == r.sync3[gi]) ? r.sync3[gi] : r.code[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Byte-lane write merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            m[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////
   // Field views
   logic enable;
   logic freerun;
   logic signed_mode;
   logic [1:0] res;
   logic [2:0] presc_sel;
   adcsq_in_type_t in_type;
   logic [2:0] gain_sel;
   logic [3:0] pos_base;
   logic [2:0] neg_sel;
   logic [3:0] scan_cnt;
   logic [6:0] samp_ext;
   logic [11:0] thresh;
   logic cmp_above;
   logic cfg_err;

   assign enable = r.ctrl[ADCSQ_CTRL_ENABLE];
   assign freerun = r.ctrl[ADCSQ_CTRL_FREERUN];
   assign signed_mode = r.cfg[ADCSQ_CFG_SIGNED];
   assign res = r.cfg[ADCSQ_CFG_RES_LO +: 2];
   assign presc_sel = r.cfg[ADCSQ_CFG_PRESC_LO +: 3];
   assign in_type = adcsq_in_type_t'(r.insel[ADCSQ_INSEL_TYPE_LO +: 2]);
   assign gain_sel = r.insel[ADCSQ_INSEL_GAIN_LO +: 3];
   assign pos_base = r.insel[ADCSQ_INSEL_POS_LO +: 4];
   assign neg_sel = r.insel[ADCSQ_INSEL_NEG_LO +: 3];
   assign scan_cnt = r.insel[ADCSQ_INSEL_SCAN_LO +: 4];
   assign samp_ext = r.samp[6:0];
   assign thresh = r.cmp[11:0];
   assign cmp_above = r.cmp[ADCSQ_CMP_ABOVE];
   // Differential selection while unsigned is flagged for software
   assign cfg_err = (in_type[1] && !signed_mode);

   ////////////////////////////////////////////////////////////////////////
   // Converter clock prescaler: half period of 2^n peripheral cycles
   logic [6:0] presc_top;
   logic half_tick;
   logic rise_tick;
   assign presc_top = 7'((8'h01 << presc_sel) - 8'h01);
   assign half_tick = enable && (r.presc >= presc_top);
   assign rise_tick = half_tick && !r.ana.converter_clock;

   ////////////////////////////////////////////////////////////////////////
   // Conversion length in half cycles
   logic [7:0] gain_half;
   logic [7:0] conv_half;
   logic [7:0] samp_half;
   always_comb begin
      // Each doubling adds half a cycle; one half also takes one
      if (in_type != ADCSQ_IN_DIFF_GAIN) begin
         gain_half = 8'h00;
      end else if (gain_sel == ADCSQ_GAIN_HALF) begin
         gain_half = 8'h01;
      end else begin
         gain_half = {5'h00, gain_sel};
      end
   end
   assign samp_half = ADCSQ_HALF_SAMPLE + {1'b0, samp_ext};
   assign conv_half = ((res == ADCSQ_RES_8R) ? ADCSQ_HALF_8 : ADCSQ_HALF_12)
                      + {1'b0, samp_ext} + gain_half;

   ////////////////////////////////////////////////////////////////////////
   // Result formatting and compare
   logic [15:0] fmt;
   logic [11:0] cval;
   logic hit;
   always_comb begin
      unique case (res)
         ADCSQ_RES_8R: begin
            fmt = signed_mode ? {{8{r.code[11]}}, r.code[11:4]}
                              : {8'h00, r.code[11:4]};
            cval = {r.code[11:4], 4'h0};
         end
         ADCSQ_RES_12L: begin
            fmt = {r.code, 4'h0};
            cval = r.code;
         end
         ADCSQ_RES_12R, ADCSQ_RES_RSVD: begin
            fmt = signed_mode ? {{4{r.code[11]}}, r.code}
                              : {4'h0, r.code};
            cval = r.code;
         end
      endcase
   end
   always_comb begin
      if (signed_mode) begin
         hit = cmp_above ? ($signed(cval) > $signed(thresh))
                         : ($signed(cval) < $signed(thresh));
      end else begin
         hit = cmp_above ? (cval > thresh) : (cval < thresh);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input routing for the current position
   logic [3:0] cur_pos;
   adcsq_ana_t route;
   assign cur_pos = 4'(pos_base + r.scan_off);
   always_comb begin
      route = r.ana;
      route.pos_sel = cur_pos;
      route.pos_internal = (in_type == ADCSQ_IN_INTERNAL);
      route.gain_en = (in_type == ADCSQ_IN_DIFF_GAIN);
      route.gain = gain_sel;
      route.neg_pin = 3'h0;
      unique case (in_type)
         ADCSQ_IN_DIFF_GAIN: begin
            route.neg_mode = ADCSQ_NEG_PIN;
            route.neg_pin = {1'b1, neg_sel[1:0]};
         end
         ADCSQ_IN_DIFF: begin
            route.neg_mode = (neg_sel[2]) ? ADCSQ_NEG_INT_GND : ADCSQ_NEG_PIN;
            route.neg_pin = {1'b0, neg_sel[1:0]};
         end
         ADCSQ_IN_SINGLE, ADCSQ_IN_INTERNAL: begin
            route.neg_mode = signed_mode ? ADCSQ_NEG_INT_GND
                                         : ADCSQ_NEG_HALF_VREF;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus read mux
   logic [31:0] rd;
   logic hit_adr;
   always_comb begin
      hit_adr = 1'b1;
      unique case (wb_req_i.adr)
         ADCSQ_OFF_CTRL: rd = r.ctrl;
         ADCSQ_OFF_CFG: rd = r.cfg;
         ADCSQ_OFF_INSEL: rd = r.insel;
         ADCSQ_OFF_SAMP: rd = r.samp;
         ADCSQ_OFF_CMP: rd = r.cmp;
         ADCSQ_OFF_RESULT: rd = {16'h0000, r.result};
         ADCSQ_OFF_STATUS: rd = {28'h0000000, cfg_err, r.ana.busy, r.st_cmp, r.st_done};
         default: begin
            rd = 32'h0000_0000;
            hit_adr = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   logic take;
   logic wr;
   logic start_req;
   logic finish;
   logic more_scan;
   logic [31:0] wd_ctrl;
   logic [31:0] wd_status;
   assign take = wb_req_i.cyc && wb_req_i.stb && !r.rsp.ack;
   assign wr = take && wb_req_i.we;
   assign start_req = r.ctrl[ADCSQ_CTRL_START] || r.ev_pend;
   assign finish = (r.state == ADCSQ_S_RUN) && half_tick && (r.half == r.half_last);
   assign more_scan = (r.scan_off < scan_cnt);
   assign wd_ctrl = merge(r.ctrl, wb_req_i.dat, wb_req_i.sel);
   assign wd_status = merge(32'h0000_0000, wb_req_i.dat, wb_req_i.sel);

   always_comb begin
      next_r = r;
      next_r.sync1 = conv_code_i;
      next_r.sync2 = r.sync1;
      next_r.sync3 = r.sync2;
      next_r.code = next_code;
      next_r.done_ev = 1'b0;
      next_r.cmp_ev = 1'b0;
      next_r.rsp.ack = take;
      next_r.rsp.dat = take ? (wb_req_i.we ? 32'h0000_0000 : rd) : 32'h0000_0000;
      if (event_start_i && enable) begin
         next_r.ev_pend = 1'b1;
      end

      // Prescaler and converter clock level
      if (!enable) begin
         next_r.presc = 7'h00;
         next_r.ana.converter_clock = 1'b0;
      end else if (half_tick) begin
         next_r.presc = 7'h00;
         next_r.ana.converter_clock = !r.ana.converter_clock;
      end else begin
         next_r.presc = 7'(r.presc + 7'h01);
      end

      // Sequencer
      unique case (r.state)
         ADCSQ_S_IDLE: begin
            next_r.ana.busy = 1'b0;
            next_r.ana.sample = 1'b0;
            // Pending start is taken only on a converter rising edge
            if (rise_tick && start_req) begin
               next_r.state = ADCSQ_S_RUN;
               next_r.ana = route;
               next_r.ana.converter_clock = 1'b1;
               next_r.ana.busy = 1'b1;
               next_r.ana.sample = 1'b1;
               next_r.half = 8'h00;
               next_r.half_last = conv_half - 8'h01;
               next_r.ctrl[ADCSQ_CTRL_START] = 1'b0;
               next_r.ev_pend = event_start_i;
            end
         end
         ADCSQ_S_RUN: begin
            if (half_tick) begin
               next_r.half = 8'(r.half + 8'h01);
               if (8'(r.half + 8'h01) >= samp_half) begin
                  next_r.ana.sample = 1'b0;
               end
            end
            if (finish) begin
               next_r.result = fmt;
               next_r.st_done = 1'b1;
               next_r.done_ev = 1'b1;
               if (hit) begin
                  next_r.st_cmp = 1'b1;
                  next_r.cmp_ev = 1'b1;
               end
               // Back-to-back continuation on the same converter clock edge as the finish
               if (more_scan || freerun || start_req) begin
                  next_r.scan_off = more_scan ? 4'(r.scan_off + 4'h1) : 4'h0;
                  next_r.half = 8'h00;
                  next_r.half_last = conv_half - 8'h01;
                  next_r.ana.sample = 1'b1;
                  next_r.ana.pos_sel = more_scan ? 4'(cur_pos + 4'h1) : pos_base;
                  next_r.ctrl[ADCSQ_CTRL_START] = 1'b0;
                  next_r.ev_pend = event_start_i;
               end else begin
                  next_r.state = ADCSQ_S_IDLE;
                  next_r.scan_off = 4'h0;
                  next_r.ana.busy = 1'b0;
                  next_r.ana.sample = 1'b0;
               end
            end
            if (!enable) begin
               next_r.state = ADCSQ_S_IDLE;
               next_r.scan_off = 4'h0;
               next_r.ana.busy = 1'b0;
               next_r.ana.sample = 1'b0;
            end
         end
         default: begin
            next_r.state = ADCSQ_S_IDLE;
         end
      endcase

      // Register writes; hardware set of a flag beats the software clear
      if (wr && hit_adr) begin
         unique case (wb_req_i.adr)
            ADCSQ_OFF_CTRL: begin
               next_r.ctrl = {28'h0000000, wd_ctrl[3:2], 1'b0, wd_ctrl[0]};
               if (!wd_ctrl[ADCSQ_CTRL_START] && r.ctrl[ADCSQ_CTRL_START]) begin
                  next_r.ctrl[ADCSQ_CTRL_START] = next_r.ctrl[ADCSQ_CTRL_START];
               end
            end
            ADCSQ_OFF_CFG: next_r.cfg = merge(r.cfg, wb_req_i.dat, wb_req_i.sel)
                                        & 32'h0000_0716;
            ADCSQ_OFF_INSEL: next_r.insel = merge(r.insel, wb_req_i.dat, wb_req_i.sel)
                                            & 32'h000F_7F1F;
            ADCSQ_OFF_SAMP: next_r.samp = merge(r.samp, wb_req_i.dat, wb_req_i.sel)
                                          & {25'h0000000, ADCSQ_HALF_EXT_MAX};
            ADCSQ_OFF_CMP: next_r.cmp = merge(r.cmp, wb_req_i.dat, wb_req_i.sel)
                                        & 32'h0001_0FFF;
            ADCSQ_OFF_STATUS: begin
               if (wd_status[ADCSQ_ST_DONE] && !(finish)) begin
                  next_r.st_done = 1'b0;
               end
               if (wd_status[ADCSQ_ST_CMP] && !(finish && hit)) begin
                  next_r.st_cmp = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
         r.ctrl <= ADCSQ_RST_REG;
         r.cfg <= ADCSQ_RST_REG;
         r.state <= ADCSQ_S_IDLE;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   assign wb_rsp_o = r.rsp;
   assign ana_o = r.ana;
   assign done_event_o = r.done_ev;
   assign cmp_event_o = r.cmp_ev;

endmodule : adcsq_top
